// ===== src/bdis_steer.v
// Notes on behaviour
// - each board dma request routes to legal channel
// - board ack follows routed channel's internal ack
// - each dma pair has own route register
// - board irq routes to legal internal irq input
// - each board irq line has own route
// - routed irq masks isa irq unless sharing
// - timer enable turns irq pin0 into output
`include "bdis_defines.vh"
`default_nettype none
module bdis_steer #(
    parameter NDMA = 2,
    parameter NIRQ = 2
) (
    // clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // ahb-lite slave
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    // board pins
    input  wire [NDMA-1:0]  board_dma_request,
    output reg  [NDMA-1:0]  board_dma_ack_n,
    input  wire [NIRQ-1:0]  board_irq_line,
    output reg              board_irq0_or_timer_irq_out,
    output reg              board_irq0_oe_n,
    // internal dma controller
    output reg  [7:0]       dma_chan_request,
    input  wire [7:0]       dma_chan_ack,
    // internal interrupt controller
    input  wire [15:0]      isa_irq_in,
    input  wire             timer_irq,
    output reg  [15:0]      ctrl_irq_in
);
    // route registers, one per pair and per line
    reg  [7:0]  dma_route_reg [0:NDMA-1];
    reg  [7:0]  irq_route_reg [0:NIRQ-1];
    // bus data-phase capture
    reg         wr_pend_reg;
    reg  [2:0]  wr_idx_reg;
    // pin synchronisers
    reg  [NDMA-1:0] dreq_s1_reg, dreq_s2_reg;
    reg  [NIRQ-1:0] irq_s1_reg,  irq_s2_reg;
    // decoded destinations, one slice per pair and per line; kept flat so the
    // combinational decode below never has to be sensitive to a whole array
    wire [8*NDMA-1:0]  dma_hot;
    wire [16*NIRQ-1:0] irq_hot;
    wire [NIRQ-1:0]    irq_share;           // share bit of each line's route
    wire        timer_en = irq_route_reg[0][`BDIS_IRQ_TIMER_BIT];
    wire        acc      = hsel && htrans[1] && hready;
    // next values of the registered steering outputs
    reg  [7:0]       dma_req_next;
    reg  [NDMA-1:0]  dma_ack_n_next;
    reg  [15:0]      ctrl_irq_next;
    reg  [15:0]      isa_keep;              // bus interrupts left after masking
    // one loop index per process, so no variable has two drivers
    integer     k;                          // bus slave and its reset
    integer     j;                          // steering decode
    // word index of a byte address; 7 means unmapped
    // unmapped words read zero and drop writes
    function [2:0] reg_idx;
        input [31:0] a;
        begin
            if (a[31:5] != 27'h0 || a[1:0] != 2'b00 || a[4:2] > 3'h4)
                reg_idx = 3'h7;
            else
                reg_idx = a[4:2];
        end
    endfunction
    genvar g;
    generate
        for (g = 0; g < NDMA; g = g + 1)
        begin : g_dma
            bdis_route_dec #(.W(8), .SW(3)) u_dec (
                .sel    (dma_route_reg[g][`BDIS_DMA_CH_MSB:`BDIS_DMA_CH_LSB]),
                .dis    (dma_route_reg[g][`BDIS_DMA_DIS_BIT]),
                .legal  (`BDIS_DMA_LEGAL),
                .onehot (dma_hot[8*g +: 8])
            );
        end
        for (g = 0; g < NIRQ; g = g + 1)
        begin : g_irq
            bdis_route_dec #(.W(16), .SW(4)) u_dec (
                .sel    (irq_route_reg[g][`BDIS_IRQ_NUM_MSB:`BDIS_IRQ_NUM_LSB]),
                // pin 0 used as timer output routes nothing inward
                .dis    (irq_route_reg[g][`BDIS_IRQ_DIS_BIT] || (g == 0 && timer_en)),
                .legal  (`BDIS_IRQ_LEGAL),
                .onehot (irq_hot[16*g +: 16])
            );
            assign irq_share[g] = irq_route_reg[g][`BDIS_IRQ_SHARE_BIT];
        end
    endgenerate
    // two-flop synchronisers for board pins
    // only the second stage is read by the steering logic
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dreq_s1_reg <= {NDMA{1'b0}};
            dreq_s2_reg <= {NDMA{1'b0}};
            irq_s1_reg  <= {NIRQ{1'b0}};
            irq_s2_reg  <= {NIRQ{1'b0}};
        end
        else
        begin
            dreq_s1_reg <= board_dma_request;
            dreq_s2_reg <= dreq_s1_reg;
            irq_s1_reg  <= board_irq_line;
            irq_s2_reg  <= irq_s1_reg;
        end
    end
    // bus slave: zero wait states, writes land at data phase
    // a read issued right behind a write still sees the old value, since
    // the write only lands at the edge that ends its data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 3'h7;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            for (k = 0; k < NDMA; k = k + 1)
                dma_route_reg[k] <= `BDIS_ROUTE_RESET;
            for (k = 0; k < NIRQ; k = k + 1)
                irq_route_reg[k] <= `BDIS_ROUTE_RESET;
        end
        else
        begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            // address phase: remember a write for its data phase
            wr_pend_reg <= acc && hwrite;
            wr_idx_reg  <= reg_idx(haddr);
            // pending write: store low byte
            if (wr_pend_reg)
            begin
                if (wr_idx_reg < NDMA)
                    dma_route_reg[wr_idx_reg[0]] <= hwdata[7:0];
                else if (wr_idx_reg >= 3'h2 && wr_idx_reg < 3'h2 + NIRQ)
                    irq_route_reg[wr_idx_reg[0]] <= hwdata[7:0];
            end
            // read: data registered for the data phase; unmapped reads zero
            if (acc && !hwrite)
            begin
                case (reg_idx(haddr))
                    3'h0:    hrdata <= {24'h0, dma_route_reg[0]};
                    3'h1:    hrdata <= {24'h0, dma_route_reg[NDMA-1]};
                    3'h2:    hrdata <= {24'h0, irq_route_reg[0]};
                    3'h3:    hrdata <= {24'h0, irq_route_reg[NIRQ-1]};
                    // status: upper ten bits read zero
                    3'h4:    hrdata <= {10'h0, board_dma_ack_n, irq_s2_reg, dreq_s2_reg,
                                        ctrl_irq_in};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end
    // steering decode; the outputs are registered below so every top-level
    // output comes from a flop, at the cost of one cycle on each path
    always @*
    begin
        dma_req_next   = 8'h00;
        dma_ack_n_next = {NDMA{1'b1}};
        isa_keep       = isa_irq_in;
        ctrl_irq_next  = 16'h0000;
        // dma pairs: a disabled pair decodes to nothing, so its request is ignored
        for (j = 0; j < NDMA; j = j + 1)
        begin
            if (dreq_s2_reg[j])
                dma_req_next = dma_req_next | dma_hot[8*j +: 8];
            // ack asserts only while the routed channel acks
            dma_ack_n_next[j] = ~|(dma_hot[8*j +: 8] & dma_chan_ack);
        end
        // board lines: an unshared route hides the bus interrupt it lands on,
        // whether or not the board line is active at the moment
        for (j = 0; j < NIRQ; j = j + 1)
        begin
            if (!irq_share[j])
                isa_keep = isa_keep & ~irq_hot[16*j +: 16];
            if (irq_s2_reg[j])
                ctrl_irq_next = ctrl_irq_next | irq_hot[16*j +: 16];
        end
        // illegal and unrouted inputs pass the bus interrupt unchanged
        ctrl_irq_next = ctrl_irq_next | isa_keep;
    end
    // steering outputs, registered
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dma_chan_request            <= 8'h00;
            board_dma_ack_n             <= {NDMA{1'b1}};
            ctrl_irq_in                 <= 16'h0000;
            board_irq0_or_timer_irq_out <= 1'b0;
            board_irq0_oe_n             <= 1'b1;
        end
        else
        begin
            // dma and irq decoding happens above; these three flops only register it
            dma_chan_request <= dma_req_next;
            board_dma_ack_n  <= dma_ack_n_next;
            ctrl_irq_in      <= ctrl_irq_next;
            // timer output on pin 0 when enabled
            // the pin's input side is cut off meanwhile, in the irq decoder
            board_irq0_or_timer_irq_out <= timer_en & timer_irq;
            board_irq0_oe_n             <= ~timer_en;
        end
    end
endmodule // bdis_steer
`default_nettype wire

// ===== pkg/bdis_defines.vh
`ifndef BDIS_DEFINES_VH
`define BDIS_DEFINES_VH
// register byte offsets
`define BDIS_DMA0_ROUTE_OFS   8'h00
`define BDIS_DMA1_ROUTE_OFS   8'h04
`define BDIS_IRQ0_ROUTE_OFS   8'h08
`define BDIS_IRQ1_ROUTE_OFS   8'h0C
`define BDIS_STATUS_OFS       8'h10
// dma route fields: [2:0] channel, [7] disable
`define BDIS_DMA_CH_LSB       0
`define BDIS_DMA_CH_MSB       2
`define BDIS_DMA_DIS_BIT      7
// irq route fields: [3:0] irq number, [5] share, [6] timer out enable, [7] disable
`define BDIS_IRQ_NUM_LSB      0
`define BDIS_IRQ_NUM_MSB      3
`define BDIS_IRQ_SHARE_BIT    5
`define BDIS_IRQ_TIMER_BIT    6
`define BDIS_IRQ_DIS_BIT      7
// reset values: routing disabled
`define BDIS_ROUTE_RESET      8'h80
// legal destination sets
`define BDIS_DMA_LEGAL        8'hEF
`define BDIS_IRQ_LEGAL        16'hDEF8
`endif

// ===== src/bdis_route_dec.v
`default_nettype none
// one-hot decode of a route setting, gated by legality and disable
module bdis_route_dec #(
    parameter W  = 8,
    parameter SW = 3
) (
    // route setting
    input  wire [SW-1:0] sel,
    input  wire          dis,
    input  wire [W-1:0]  legal,
    // decoded destination
    output wire [W-1:0]  onehot
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_dec
            // an illegal destination routes nowhere rather than to a reserved input
            assign onehot[i] = !dis && legal[i] && (sel == i);
        end
    endgenerate
endmodule // bdis_route_dec
`default_nettype wire

// ===== dv/bdis_steer_monitor.sv
`default_nettype none
// pin-level watch on the steering block; it has no register view, so it checks causes and route-independent invariants only
module bdis_steer_monitor #(parameter NDMA = 2, parameter NIRQ = 2) (
    // clock and reset
    input wire logic            hclk,
    input wire logic            hresetn,
    // bus answer
    input wire logic            hreadyout,
    input wire logic            hresp,
    // board pins
    input wire logic [NDMA-1:0] board_dma_request,
    input wire logic [NDMA-1:0] board_dma_ack_n,
    input wire logic [NIRQ-1:0] board_irq_line,
    input wire logic            board_irq0_or_timer_irq_out,
    input wire logic            board_irq0_oe_n,
    // internal side
    input wire logic [7:0]      dma_chan_request,
    input wire logic [7:0]      dma_chan_ack,
    input wire logic [15:0]     isa_irq_in,
    input wire logic            timer_irq,
    input wire logic [15:0]     ctrl_irq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
    chan_four_a: assert property (!dma_chan_request[4]) else $error("channel four requested");
    // request needs a board request three edges back (two sync flops plus output flop)
    dreq_cause_a: assert property (|dma_chan_request |-> $past(|board_dma_request, 3))
        else $error("channel request without board request");
    ack_cause_a: assert property (~&board_dma_ack_n |-> $past(|dma_chan_ack))
        else $error("board ack without internal ack");
    // illegal destinations carry the bus interrupt untouched
    irq_fixed_a: assert property ($past(hresetn) |-> (ctrl_irq_in & 16'h2107) == ($past(isa_irq_in) & 16'h2107))
        else $error("illegal irq input disturbed");
    irq_cause_a: assert property ($past(hresetn) && |(ctrl_irq_in & ~$past(isa_irq_in)) |->
        $past(|board_irq_line, 3)) else $error("irq raised without a cause");
    timer_out_a: assert property (!board_irq0_oe_n && !$past(board_irq0_oe_n) |->
        board_irq0_or_timer_irq_out == $past(timer_irq)) else $error("pin0 not following timer");
    timer_idle_a: assert property (board_irq0_oe_n && $past(board_irq0_oe_n) |-> !board_irq0_or_timer_irq_out)
        else $error("pin0 output active while released");
    ack_cov: cover property (~&board_dma_ack_n);
    pin_cov: cover property (!board_irq0_oe_n && timer_irq);
    req_cov: cover property (dma_chan_request[7]);
endmodule // bdis_steer_monitor
bind bdis_steer bdis_steer_monitor #(.NDMA(NDMA), .NIRQ(NIRQ)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .board_dma_request(board_dma_request), .board_dma_ack_n(board_dma_ack_n),
    .board_irq_line(board_irq_line), .board_irq0_or_timer_irq_out(board_irq0_or_timer_irq_out),
    .board_irq0_oe_n(board_irq0_oe_n), .dma_chan_request(dma_chan_request), .dma_chan_ack(dma_chan_ack),
    .isa_irq_in(isa_irq_in), .timer_irq(timer_irq), .ctrl_irq_in(ctrl_irq_in));
`default_nettype wire

// ===== dv/bdis_periph.sv
`default_nettype none
// board peripherals: level requests that drop once acknowledged, active-high level interrupts
module bdis_periph (
    // clock
    input wire logic       hclk,
    // bench commands
    input wire logic [1:0] dreq_go,
    input wire logic [1:0] irq_go,
    // board pins
    input wire logic [1:0] board_dma_ack_n,
    output var logic [1:0] board_dma_request,
    output var logic [1:0] board_irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // a real peripheral withdraws its request when served, so the model does too
    always @(posedge hclk)
    begin
        board_dma_request <= dreq_go & board_dma_ack_n;
        board_irq_line <= irq_go;
    end
endmodule // bdis_periph
`default_nettype wire

// ===== dv/bdis_steer_tb.sv
`default_nettype none
// self-checking bench: one bus task, one task per scenario
module bdis_steer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define BDIS_CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
        $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
    logic        hclk, hresetn, hwrite, tmr, tout, toe_n, hrdy, hresp;
    logic [1:0]  htrans, dgo, igo, dack_n, dreq, pirq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  dcreq, dcack;
    logic [15:0] isa, ctrl;
    int          fails, cmp_count;
    // pin 0 is two-way: the device owns it while its enable is low
    wire logic [1:0] irq_wire = {pirq[1], toe_n ? pirq[0] : tout};
    bdis_steer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .board_dma_request(dreq), .board_dma_ack_n(dack_n), .board_irq_line(irq_wire),
        .board_irq0_or_timer_irq_out(tout), .board_irq0_oe_n(toe_n), .dma_chan_request(dcreq),
        .dma_chan_ack(dcack), .isa_irq_in(isa), .timer_irq(tmr), .ctrl_irq_in(ctrl));
    bdis_periph u_per (.hclk(hclk), .dreq_go(dgo), .irq_go(igo), .board_dma_ack_n(dack_n),
        .board_dma_request(dreq), .board_irq_line(pirq));
    // single word transfer; entered just after an edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'h1);
        rd = hrdata;
    endtask
    // routes reset disabled, status shows both acks negated; unmapped space reads zero
    task automatic t_regs;
        for (int i = 0; i < 6; i++)
        begin
            bus(1'h0, 4 * i + ((i == 5) ? 12 : 0), 32'h0);
            `BDIS_CHK(rd, (i == 5) ? 32'h0 : (i == 4) ? 32'h0030_0000 : 32'h80)
        end
    endtask
    // every channel on each pair, the other pair off; channel four goes nowhere
    task automatic t_dma;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 8; c++)
            begin
                bus(1'h1, 4 * p, c);
                bus(1'h1, 4 - 4 * p, 32'h80);
                dgo <= 2'h3;
                repeat (5) @(posedge hclk);
                `BDIS_CHK(dcreq, (c == 4) ? 8'h00 : 8'h01 << c)
                dcack <= 8'h01 << c;
                repeat (2) @(posedge hclk);
                `BDIS_CHK(dack_n, (c == 4) ? 2'h3 : ~(2'h1 << p))
                dgo <= 2'h0;
                dcack <= 8'h00;
                repeat (6) @(posedge hclk);
            end
    endtask
    // line 1 over each legal input, line 0 left disabled but active
    task automatic t_irq;
        for (int n = 0; n < 16; n++)
            if ((16'hDEF8 >> n) & 16'h1)
            begin
                bus(1'h1, 32'hC, n);
                isa <= 16'h0;
                igo <= 2'h3;
                repeat (5) @(posedge hclk);
                `BDIS_CHK(ctrl, 16'h1 << n)
                isa <= 16'hFFFF;
                igo <= 2'h0;
                repeat (5) @(posedge hclk);
                `BDIS_CHK(ctrl, ~(16'h1 << n))
                bus(1'h1, 32'hC, n | 32'h20);
                repeat (2) @(posedge hclk);
                `BDIS_CHK(ctrl, 16'hFFFF)
            end
    endtask
    // pin 0 turned into the timer output and back
    task automatic t_timer;
        bus(1'h1, 32'h8, 32'h40);
        tmr <= 1'h1;
        repeat (3) @(posedge hclk);
        `BDIS_CHK({toe_n, tout}, 2'h1)
        bus(1'h1, 32'h8, 32'h80);
        repeat (3) @(posedge hclk);
        `BDIS_CHK({toe_n, tout}, 2'h2)
    endtask
    task automatic stop_test;
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    initial
    begin
        {hresetn, hwrite, tmr, htrans, dgo, igo, haddr, hwdata, dcack, isa} = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs;
        t_dma;
        t_irq;
        t_timer;
        stop_test;
    end
    // the tests need under five hundred cycles; 25000 means a hang
    initial
    begin
        #200000;
        fails++;
        stop_test;
    end
endmodule // bdis_steer_tb
`default_nettype wire
